/* File: include/ccd_pkg.sv */
// Purpose: Constants for the comb decimator and coefficient filter block
// Assumes: APB register access, one 50 MHz clock
// Notes:   Register indexes are word indexes; byte address is index times four
`default_nettype none
package ccd_pkg;
    // ----------------------------------------------------------------
    // Widths and depths
    // ----------------------------------------------------------------
    localparam int CCD_DW = 20;
    localparam int CCD_OW = 24;
    localparam int CCD_IW = 45;
    localparam int CCD_ACCW = 48;
    localparam int CCD_AW = 12;
    localparam int CCD_DEPTH = 160;
    localparam int CCD_CDEPTH = 256;
    localparam int CCD_OUT_LSB = 19;
    localparam logic [8:0] CCD_DEPTH_W = 9'h0a0;
    localparam logic [7:0] CCD_TAPS_MAX_M1 = 8'h9f;
    localparam logic [7:0] CCD_WP_LAST = 8'h9f;
    // ----------------------------------------------------------------
    // Register indexes
    // ----------------------------------------------------------------
    localparam logic [9:0] IDX_COEF_LAST = 10'h07f;
    localparam logic [9:0] IDX_DEC = 10'h0a0;
    localparam logic [9:0] IDX_PHASE = 10'h0a1;
    localparam logic [9:0] IDX_TAPS = 10'h0a2;
    localparam logic [9:0] IDX_OFFSET = 10'h0a3;
    localparam logic [9:0] IDX_CTRL = 10'h0a4;
    localparam logic [9:0] IDX_COMB = 10'h0a5;
    localparam logic [9:0] IDX_STATUS = 10'h0a6;
    // ----------------------------------------------------------------
    // Fields and reset values
    // ----------------------------------------------------------------
    localparam int CTRL_PAGE_BIT = 8;
    localparam int CTRL_W = 11;
    localparam int COMB_RATIO_LSB = 0;
    localparam int COMB_ATT_LSB = 8;
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_WP_LSB = 8;
    localparam logic [4:0] COMB_RATIO_M1_RST = 5'h01;
    localparam logic [4:0] COMB_ATT_RST = 5'h00;
    localparam logic [4:0] COMB_ATT_MAX = 5'h14;
    localparam logic [5:0] COMB_SHIFT_BASE = 6'h05;
    localparam logic [7:0] FIR_REG_RST = 8'h00;
    localparam logic [CTRL_W-1:0] CTRL_RST = 11'h000;
    // ----------------------------------------------------------------
    // Filter sequencer states
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        FS_IDLE = 3'b001,
        FS_RUN = 3'b010,
        FS_DONE = 3'b100
    } ccd_fstate_t;
endpackage
`default_nettype wire

/* File: hdl/ccd_top.sv */
// Purpose: Fifth-order comb decimator feeding a RAM-coefficient FIR decimator
// Assumes: Upstream samples arrive on ref_clk with a one-cycle valid strobe
// Notes:   One I and one Q tap per clock; software keeps tap count within budget
//
// Overview of operation
// - Comb decimation ratio from 2 to 32
// - Five unity integrator-comb sections, gain over 2^(S+5)
// - Attenuation setting 0..20, 6 dB steps
// - Comb output rate is input over ratio
// - Comb accepts a sample every clock cycle
// - Keep newest 160 complex 20-bit samples
// - Coefficient memory holds 256 20-bit words
// - One I and one Q tap per cycle
// - Outputs are 24-bit I and Q words
// - FIR decimation register holds ratio minus one
// - FIR decimation counter preloads from phase register
// - Tap count minus one; hardware clamps it to 160 taps
// - Coefficients written via 128-word window, two's complement
// - Low coefficient addresses multiply older samples
// - Page select bit chooses written coefficient page
// - Pages are contiguous during computation
// - Sample memory is 160 by 40 circular buffer
// - Start at oldest sample and offset coefficient
// - FIR output rate is comb rate over ratio
// - Page low writes taps 0..127, high 128..255
`timescale 1ns/100ps
`default_nettype none
module ccd_top
    import ccd_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic resetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [CCD_AW-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Upstream sample stream
    input wire logic in_valid,
    input wire logic [CCD_DW-1:0] in_i,
    input wire logic [CCD_DW-1:0] in_q,
    // Filter output stream
    output logic out_valid,
    output logic [CCD_OW-1:0] out_i,
    output logic [CCD_OW-1:0] out_q
);
    // ----------------------------------------------------------------
    // Register file
    // ----------------------------------------------------------------
    logic [7:0] dec_m1_ff, nxt_dec_m1;
    logic [7:0] phase_ff, nxt_phase;
    logic [7:0] taps_m1_ff, nxt_taps_m1;
    logic [7:0] offset_ff, nxt_offset;
    logic [CTRL_W-1:0] ctrl_ff, nxt_ctrl;
    logic [4:0] comb_ratio_m1_ff, nxt_comb_ratio_m1;
    logic [4:0] comb_att_ff, nxt_comb_att;
    logic pready_ff, nxt_pready;
    logic pslverr_ff, nxt_pslverr;
    logic [31:0] prdata_ff, nxt_prdata;
    logic [9:0] idx;
    logic wr_go;
    logic phase_wr;
    logic [8:0] wp_ff, nxt_wp;
    ccd_fstate_t fst_ff, nxt_fst;

    assign idx = paddr[11:2];
    assign wr_go = psel && penable && pready_ff && pwrite;
    assign phase_wr = wr_go && (idx == IDX_PHASE);

    always_comb begin
        nxt_dec_m1 = dec_m1_ff;
        nxt_phase = phase_ff;
        nxt_taps_m1 = taps_m1_ff;
        nxt_offset = offset_ff;
        nxt_ctrl = ctrl_ff;
        nxt_comb_ratio_m1 = comb_ratio_m1_ff;
        nxt_comb_att = comb_att_ff;
        nxt_prdata = prdata_ff;
        nxt_pslverr = 1'b0;
        // Zero-wait slave: ready in the first access cycle
        nxt_pready = psel && !penable && !pready_ff;
        if (psel && !penable) begin
            nxt_prdata = 32'h0000_0000;
            case (idx)
                IDX_DEC: nxt_prdata[7:0] = dec_m1_ff;
                IDX_PHASE: nxt_prdata[7:0] = phase_ff;
                IDX_TAPS: nxt_prdata[7:0] = taps_m1_ff;
                IDX_OFFSET: nxt_prdata[7:0] = offset_ff;
                IDX_CTRL: nxt_prdata[CTRL_W-1:0] = ctrl_ff;
                IDX_COMB: begin
                    nxt_prdata[COMB_RATIO_LSB +: 5] = comb_ratio_m1_ff;
                    nxt_prdata[COMB_ATT_LSB +: 5] = comb_att_ff;
                end
                IDX_STATUS: begin
                    nxt_prdata[STAT_BUSY_BIT] = (fst_ff != FS_IDLE);
                    nxt_prdata[STAT_WP_LSB +: 9] = wp_ff;
                end
                default: begin
                    // Coefficient window is write-only and reads zero
                    nxt_pslverr = (idx > IDX_COEF_LAST);
                end
            endcase
        end
        if (wr_go) begin
            case (idx)
                IDX_DEC: nxt_dec_m1 = pwdata[7:0];
                IDX_PHASE: nxt_phase = pwdata[7:0];
                IDX_TAPS: nxt_taps_m1 = pwdata[7:0];
                IDX_OFFSET: nxt_offset = pwdata[7:0];
                IDX_CTRL: nxt_ctrl = pwdata[CTRL_W-1:0];
                IDX_COMB: begin
                    // Ratio 1 is out of range; hold at least 2
                    nxt_comb_ratio_m1 = (pwdata[COMB_RATIO_LSB +: 5] == 5'h00) ? 5'h01
                                        : pwdata[COMB_RATIO_LSB +: 5];
                    nxt_comb_att = (pwdata[COMB_ATT_LSB +: 5] > COMB_ATT_MAX) ? COMB_ATT_MAX
                                   : pwdata[COMB_ATT_LSB +: 5];
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            dec_m1_ff <= FIR_REG_RST;
            phase_ff <= FIR_REG_RST;
            taps_m1_ff <= FIR_REG_RST;
            offset_ff <= FIR_REG_RST;
            ctrl_ff <= CTRL_RST;
            comb_ratio_m1_ff <= COMB_RATIO_M1_RST;
            comb_att_ff <= COMB_ATT_RST;
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff <= 32'h0000_0000;
        end else begin
            dec_m1_ff <= nxt_dec_m1;
            phase_ff <= nxt_phase;
            taps_m1_ff <= nxt_taps_m1;
            offset_ff <= nxt_offset;
            ctrl_ff <= nxt_ctrl;
            comb_ratio_m1_ff <= nxt_comb_ratio_m1;
            comb_att_ff <= nxt_comb_att;
            pready_ff <= nxt_pready;
            pslverr_ff <= nxt_pslverr;
            prdata_ff <= nxt_prdata;
        end
    end

    assign pready = pready_ff;
    assign pslverr = pslverr_ff;
    assign prdata = prdata_ff;

    // ----------------------------------------------------------------
    // Coefficient memory
    // ----------------------------------------------------------------
    logic [CCD_DW-1:0] coef_mem [CCD_CDEPTH];

    // Page bit forms the top address bit, so the pages meet at tap 127/128
    always_ff @(posedge ref_clk) begin
        if (wr_go && (idx <= IDX_COEF_LAST)) begin
            coef_mem[{ctrl_ff[CTRL_PAGE_BIT], idx[6:0]}] <= pwdata[CCD_DW-1:0];
        end
    end

    // ----------------------------------------------------------------
    // Fifth-order comb decimator
    // ----------------------------------------------------------------
    logic signed [CCD_IW-1:0] integ_ff [2][5];
    logic signed [CCD_IW-1:0] nxt_integ [2][5];
    logic signed [CCD_IW-1:0] dly_ff [2][5];
    logic signed [CCD_IW-1:0] nxt_dly [2][5];
    logic [4:0] cic_cnt_ff, nxt_cic_cnt;
    logic smp_valid_ff, nxt_smp_valid;
    logic [CCD_DW-1:0] smp_ff [2];
    logic [CCD_DW-1:0] nxt_smp [2];
    logic signed [CCD_IW-1:0] in_ext [2];
    logic [5:0] shamt;

    assign in_ext[0] = CCD_IW'($signed(in_i));
    assign in_ext[1] = CCD_IW'($signed(in_q));
    assign shamt = {1'b0, comb_att_ff} + COMB_SHIFT_BASE;

    always_comb begin
        logic signed [CCD_IW-1:0] stage;
        logic signed [CCD_IW-1:0] scaled;
        stage = '0;
        scaled = '0;
        nxt_integ = integ_ff;
        nxt_dly = dly_ff;
        nxt_cic_cnt = cic_cnt_ff;
        nxt_smp = smp_ff;
        nxt_smp_valid = 1'b0;
        // Integrators run at the input rate, one sample per clock at most
        if (in_valid) begin
            for (int ch = 0; ch < 2; ch++) begin
                nxt_integ[ch][0] = integ_ff[ch][0] + in_ext[ch];
                for (int k = 1; k < 5; k++) begin
                    nxt_integ[ch][k] = integ_ff[ch][k] + integ_ff[ch][k-1];
                end
            end
            nxt_cic_cnt = cic_cnt_ff + 5'h01;
            if (cic_cnt_ff >= comb_ratio_m1_ff) begin
                nxt_cic_cnt = 5'h00;
                nxt_smp_valid = 1'b1;
                for (int ch = 0; ch < 2; ch++) begin
                    stage = integ_ff[ch][4];
                    for (int k = 0; k < 5; k++) begin
                        nxt_dly[ch][k] = stage;
                        stage = stage - dly_ff[ch][k];
                    end
                    // Wrapping arithmetic makes the comb output exact
                    scaled = stage >>> shamt;
                    nxt_smp[ch] = scaled[CCD_DW-1:0];
                end
            end
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            for (int ch = 0; ch < 2; ch++) begin
                for (int k = 0; k < 5; k++) begin
                    integ_ff[ch][k] <= '0;
                    dly_ff[ch][k] <= '0;
                end
                smp_ff[ch] <= '0;
            end
            cic_cnt_ff <= 5'h00;
            smp_valid_ff <= 1'b0;
        end else begin
            integ_ff <= nxt_integ;
            dly_ff <= nxt_dly;
            smp_ff <= nxt_smp;
            cic_cnt_ff <= nxt_cic_cnt;
            smp_valid_ff <= nxt_smp_valid;
        end
    end

    // ----------------------------------------------------------------
    // Sample memory, circular
    // ----------------------------------------------------------------
    logic [2*CCD_DW-1:0] data_mem [CCD_DEPTH];

    always_ff @(posedge ref_clk) begin
        if (smp_valid_ff) begin
            data_mem[wp_ff[7:0]] <= {smp_ff[0], smp_ff[1]};
        end
    end

    // ----------------------------------------------------------------
    // Coefficient filter sequencer
    // ----------------------------------------------------------------
    logic [7:0] fir_cnt_ff, nxt_fir_cnt;
    logic [8:0] rd_ff, nxt_rd;
    logic [7:0] caddr_ff, nxt_caddr;
    logic [7:0] left_ff, nxt_left;
    logic signed [CCD_ACCW-1:0] acc_ff [2];
    logic signed [CCD_ACCW-1:0] nxt_acc [2];
    logic out_valid_ff, nxt_out_valid;
    logic [CCD_OW-1:0] out_ff [2];
    logic [CCD_OW-1:0] nxt_out [2];
    logic [2*CCD_DW-1:0] tap_data;
    logic signed [CCD_DW-1:0] tap_coef;
    logic [7:0] taps_m1_lim;

    assign tap_data = data_mem[rd_ff[7:0]];
    assign tap_coef = $signed(coef_mem[caddr_ff]);
    // Tap count cannot exceed the sample memory depth
    assign taps_m1_lim = (taps_m1_ff > CCD_TAPS_MAX_M1) ? CCD_TAPS_MAX_M1 : taps_m1_ff;

    always_comb begin
        logic [8:0] wp_next;
        logic [8:0] ntaps;
        logic start;
        logic signed [2*CCD_DW-1:0] prod_i;
        logic signed [2*CCD_DW-1:0] prod_q;
        wp_next = wp_ff;
        ntaps = {1'b0, taps_m1_lim} + 9'h001;
        start = 1'b0;
        prod_i = $signed(tap_data[2*CCD_DW-1:CCD_DW]) * tap_coef;
        prod_q = $signed(tap_data[CCD_DW-1:0]) * tap_coef;
        nxt_wp = wp_ff;
        nxt_fir_cnt = fir_cnt_ff;
        nxt_fst = fst_ff;
        nxt_rd = rd_ff;
        nxt_caddr = caddr_ff;
        nxt_left = left_ff;
        nxt_acc = acc_ff;
        nxt_out_valid = 1'b0;
        nxt_out = out_ff;
        if (smp_valid_ff) begin
            wp_next = (wp_ff[7:0] == CCD_WP_LAST) ? 9'h000 : wp_ff + 9'h001;
            nxt_wp = wp_next;
            if (fir_cnt_ff == dec_m1_ff) begin
                nxt_fir_cnt = 8'h00;
                start = 1'b1;
            end else begin
                nxt_fir_cnt = fir_cnt_ff + 8'h01;
            end
        end
        // A new phase restarts the count from that value
        if (phase_wr) begin
            nxt_fir_cnt = pwdata[7:0];
        end
        case (fst_ff)
            FS_IDLE: begin
                // Starts arriving mid-computation are dropped; software budgets taps
                if (start) begin
                    nxt_rd = (wp_next >= ntaps) ? wp_next - ntaps : wp_next + CCD_DEPTH_W - ntaps;
                    nxt_caddr = offset_ff;
                    nxt_left = taps_m1_lim;
                    nxt_acc[0] = '0;
                    nxt_acc[1] = '0;
                    nxt_fst = FS_RUN;
                end
            end
            FS_RUN: begin
                nxt_acc[0] = acc_ff[0] + CCD_ACCW'(prod_i);
                nxt_acc[1] = acc_ff[1] + CCD_ACCW'(prod_q);
                // Older sample pairs with lower coefficient address
                nxt_rd = (rd_ff[7:0] == CCD_WP_LAST) ? 9'h000 : rd_ff + 9'h001;
                nxt_caddr = caddr_ff + 8'h01;
                nxt_left = left_ff - 8'h01;
                if (left_ff == 8'h00) begin
                    nxt_fst = FS_DONE;
                end
            end
            FS_DONE: begin
                nxt_out[0] = acc_ff[0][CCD_OUT_LSB +: CCD_OW];
                nxt_out[1] = acc_ff[1][CCD_OUT_LSB +: CCD_OW];
                nxt_out_valid = 1'b1;
                nxt_fst = FS_IDLE;
            end
            default: begin
                nxt_fst = FS_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            wp_ff <= 9'h000;
            fir_cnt_ff <= FIR_REG_RST;
            fst_ff <= FS_IDLE;
            rd_ff <= 9'h000;
            caddr_ff <= 8'h00;
            left_ff <= 8'h00;
            acc_ff[0] <= '0;
            acc_ff[1] <= '0;
            out_valid_ff <= 1'b0;
            out_ff[0] <= '0;
            out_ff[1] <= '0;
        end else begin
            wp_ff <= nxt_wp;
            fir_cnt_ff <= nxt_fir_cnt;
            fst_ff <= nxt_fst;
            rd_ff <= nxt_rd;
            caddr_ff <= nxt_caddr;
            left_ff <= nxt_left;
            acc_ff <= nxt_acc;
            out_valid_ff <= nxt_out_valid;
            out_ff <= nxt_out;
        end
    end

    assign out_valid = out_valid_ff;
    assign out_i = out_ff[0];
    assign out_q = out_ff[1];
endmodule
`default_nettype wire

/* File: test/ccd_sva.sv */
// Purpose: Port-level checks of the comb and coefficient filter block
// Assumes: Zero-wait APB slave, registered output strobe
// Notes:   Bound to ccd_top from the bench top file
`timescale 1ns/100ps
`default_nettype none
module ccd_sva
    import ccd_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic resetn,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [CCD_AW-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Streams
    input wire logic in_valid,
    input wire logic [CCD_DW-1:0] in_i,
    input wire logic [CCD_DW-1:0] in_q,
    input wire logic out_valid,
    input wire logic [CCD_OW-1:0] out_i,
    input wire logic [CCD_OW-1:0] out_q
);
    logic [9:0] ix;
    logic [7:0] idle_ff, nxt_idle;
    assign ix = paddr[11:2];
    // Cycles since the last sample; saturates so no output can appear unprompted
    always_comb nxt_idle = in_valid ? 8'h00 : ((idle_ff == 8'hff) ? idle_ff : idle_ff + 8'h01);
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) idle_ff <= 8'hff;
        else idle_ff <= nxt_idle;
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);
    a_ready_zero_wait: assert property (psel && !penable |=> pready && penable)
        else $error("pready missing in access cycle");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    a_unmapped_err: assert property (pready && ix > IDX_STATUS |-> pslverr && (pwrite || prdata == 32'h0))
        else $error("unmapped access not refused");
    a_mapped_ok: assert property (pready && (ix <= IDX_COEF_LAST || ix inside {[IDX_DEC:IDX_STATUS]})
        |-> !pslverr)
        else $error("mapped access refused");
    a_gap_err: assert property (pready && ix > IDX_COEF_LAST && ix < IDX_DEC |-> pslverr)
        else $error("gap access not refused");
    a_err_with_ready: assert property (pslverr |-> pready)
        else $error("error flag outside access cycle");
    a_coef_read: assert property (pready && !pwrite && ix <= IDX_COEF_LAST |-> prdata == 32'h0)
        else $error("coefficient window read not zero");
    a_fir_width: assert property (pready && !pwrite && ix inside {[IDX_DEC:IDX_OFFSET]}
        |-> prdata[31:8] == 24'h0)
        else $error("filter register wider than 8 bits");
    a_comb_range: assert property (pready && !pwrite && ix == IDX_COMB
        |-> prdata[4:0] != 5'h00 && prdata[12:8] <= COMB_ATT_MAX)
        else $error("comb setting out of range");
    a_ctrl_width: assert property (pready && !pwrite && ix == IDX_CTRL |-> prdata[31:CTRL_W] == '0)
        else $error("control register too wide");
    a_out_pulse: assert property (out_valid |=> !out_valid)
        else $error("output strobe longer than one cycle");
    a_out_hold: assert property (!out_valid |-> $stable(out_i) && $stable(out_q))
        else $error("output words changed without strobe");
    a_out_cause: assert property (out_valid |-> idle_ff < 8'hb4)
        else $error("output without recent sample");
    cover property (out_valid);
    cover property (pready && pslverr);
    cover property (in_valid [*8]);
endmodule
`default_nettype wire

/* File: test/ccd_src.sv */
// Purpose: Upstream resampling stage model feeding complex samples
// Assumes: Single channel, so the channel count factor is one
// Notes:   Data lines read zero before the first send and the inverted value while no sample is offered after it
`timescale 1ns/100ps
`default_nettype none
module ccd_src
    import ccd_pkg::*;
(
    // Clock
    input wire logic clk,
    // Sample stream toward the block
    output var logic in_valid,
    output var logic [CCD_DW-1:0] in_i,
    output var logic [CCD_DW-1:0] in_q
);
    initial begin
        in_valid = 1'b0;
        in_i = '0;
        in_q = '0;
    end
    // Gap of one means a sample every clock, never faster
    task send(input int n, input logic [CCD_DW-1:0] xi, input logic [CCD_DW-1:0] xq, input int gap);
        for (int k = 0; k < n; k++) begin
            @(posedge clk);
            in_valid <= 1'b1;
            in_i <= xi;
            in_q <= xq;
            repeat (gap - 1) begin
                @(posedge clk);
                in_valid <= 1'b0;
                in_i <= ~xi;
                in_q <= ~xq;
            end
        end
        @(posedge clk);
        in_valid <= 1'b0;
        in_i <= ~xi;
        in_q <= ~xq;
    endtask
endmodule
`default_nettype wire

/* File: test/tb.sv */
// Purpose: Self-checking bench for the comb and coefficient filter block
// Assumes: Constant input levels so the model needs no pipeline alignment
// Notes:   Model recomputes comb gain and tap sums with integers
`timescale 1ns/100ps
`default_nettype none
module tb;
    import ccd_pkg::*;
    logic ref_clk, resetn, psel, penable, pwrite, pready, pslverr, er;
    logic in_valid, out_valid, armed;
    logic [CCD_AW-1:0] paddr;
    logic [31:0] pwdata, prdata, rd, w0;
    logic [CCD_DW-1:0] in_i, in_q, xi, xq;
    logic [CCD_OW-1:0] out_i, out_q, ei, eq;
    logic signed [19:0] cf [256];
    logic [31:0] seed = 32'h1e;
    int bad_count, comparisons, nout, n0, first;
    int cm[3] = '{2, 32, 5};
    int cs[3] = '{0, 20, 3};
    int cr[3] = '{1, 8, 4};
    int cn[3] = '{3, 160, 100};
    int co[3] = '{0, 96, 90};
    int cg[3] = '{4, 1, 9};
    ccd_top ccd_top_inst (.ref_clk(ref_clk), .resetn(resetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .in_valid(in_valid), .in_i(in_i), .in_q(in_q),
        .out_valid(out_valid), .out_i(out_i), .out_q(out_q));
    ccd_src ccd_src_inst (.clk(ref_clk), .in_valid(in_valid), .in_i(in_i), .in_q(in_q));
    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    function logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    function logic [23:0] fexp(input int k, input logic [19:0] x);
        longint v, acc;
        logic signed [19:0] d;
        logic [63:0] a;
        v = longint'($signed(x)) * (cm[k] ** 5);
        d = v >>> (cs[k] + 5);
        acc = 0;
        for (int j = 0; j < cn[k]; j++) acc += longint'(cf[(co[k] + j) % 256]) * longint'(d);
        a = acc;
        return a[42:19];
    endfunction
    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task apb(input logic w, input logic [9:0] ix, input logic [31:0] d);
        @(posedge ref_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= {ix, 2'b00};
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        // Only the watchdog ends a wait for ready
        do begin
            @(posedge ref_clk);
        end while (pready !== 1'b1);
        chk("pready", pready, 1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task wrap_up();
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task run(input int k);
        apb(1, IDX_COMB, (cs[k] << 8) | (cm[k] - 1));
        apb(1, IDX_DEC, cr[k] - 1);
        apb(1, IDX_TAPS, cn[k] - 1); // Taps fit the clock budget per output
        apb(1, IDX_OFFSET, co[k]);
        apb(0, IDX_COMB, 0);
        chk("comb", rd, (cs[k] << 8) | (cm[k] - 1));
        apb(0, IDX_TAPS, 0);
        chk("taps", rd, cn[k] - 1);
        xi = rnd();
        xq = rnd();
        ei = fexp(k, xi);
        eq = fexp(k, xq);
        ccd_src_inst.send((cn[k] + 10) * cm[k], xi, xq, cg[k]);
        repeat (200) @(posedge ref_clk);
        apb(0, IDX_STATUS, 0);
        w0 = rd;
        n0 = nout;
        armed = 1'b1;
        ccd_src_inst.send(4 * cm[k] * cr[k], xi, xq, cg[k]);
        repeat (200) @(posedge ref_clk);
        armed = 1'b0;
        chk("out_count", nout - n0, 4);
        apb(0, IDX_STATUS, 0);
        chk("wp", rd[16:8], (w0[16:8] + 4 * cr[k]) % 160);
        chk("idle", rd[0], 0);
    endtask
    // ----------------------------------------------------------------
    // Clock, watchdog, monitor
    // ----------------------------------------------------------------
    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end
    initial begin
        repeat (40000) @(posedge ref_clk);
        bad_count++;
        wrap_up();
    end
    always @(posedge ref_clk) begin
        if (out_valid === 1'b1) begin
            nout++;
            if (armed) begin
                chk("out_i", out_i, ei);
                chk("out_q", out_q, eq);
            end
        end
    end
    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        {resetn, psel, penable, pwrite, armed} = '0;
        paddr = '0;
        pwdata = '0;
        repeat (20) @(posedge ref_clk);
        resetn <= 1'b1;
        for (int k = 0; k < 6; k++) begin
            apb(0, IDX_DEC + k, 0);
            chk("reset", rd, (k == 5) ? 1 : 0);
        end
        apb(0, 10'h0a7, 0);
        chk("bad_rd", {rd[30:0], er}, 1);
        apb(0, 10'h090, 0);
        chk("gap_rd", {rd[30:0], er}, 1);
        apb(1, IDX_COMB, 32'h1f00);
        apb(0, IDX_COMB, 0);
        chk("clamp", rd, 32'h1401);
        for (int k = 0; k < 256; k++) begin
            if (k % 128 == 0) apb(1, IDX_CTRL, (k / 128) << CTRL_PAGE_BIT);
            cf[k] = rnd();
            apb(1, k % 128, {12'h000, cf[k]});
        end
        apb(0, 10'h005, 0);
        chk("coef_rd", rd, 0);
        for (int k = 0; k < 3; k++) run(k);
        apb(1, IDX_COMB, 1);
        apb(1, IDX_DEC, 3);
        apb(1, IDX_TAPS, 2);
        for (int p = 0; p < 4; p++) begin
            apb(1, IDX_PHASE, p);
            first = 0;
            n0 = nout;
            for (int j = 1; j <= 4; j++) begin
                ccd_src_inst.send(2, 20'h00100, 20'h00200, 4);
                repeat (12) @(posedge ref_clk);
                if (first == 0 && nout != n0) first = j;
            end
            chk("phase", first, 4 - p);
        end
        wrap_up();
    end
endmodule
bind ccd_top ccd_sva ccd_sva_inst (.ref_clk(ref_clk), .resetn(resetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .in_valid(in_valid), .in_i(in_i), .in_q(in_q),
    .out_valid(out_valid), .out_i(out_i), .out_q(out_q));
`default_nettype wire
